// ---- logic/chan_start_test.sv ----
// Four-channel start synchronisation, hold-off counters and built-in tests.
// Assumes the host port, filter outputs and memories share the master clock;
// only the sync pins arrive from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: Host sleeps channels, then sets memory-test enable
// RQ2: Host waits 1600 cycles before reading result
// RQ3: Status bit 0 high while memory test runs
// RQ4: Bits 1 and 2 flag coefficient, sample failures
// RQ5: Both tests independent and per channel
// RQ6: Separate in-phase and quadrature output signatures
// RQ7: Host zeroes signatures, sleeps channel, hold-off one
// RQ8: Signature observes exactly programmed nonzero output count
// RQ9: Bits 6 and 7 choose external, random, sine
// RQ10: Software sync wakes the selected channels
// RQ11: External vectors wait for channel readiness
// RQ12: Signatures hold stable once count is reached
// RQ13: Hold-off clocked by software or four pins
// RQ14: Reset puts all channels asleep; software may too
// RQ15: Clearing sleep bit wakes channel at once
// RQ16: Unsynchronised start uses hold-off of one
// RQ17: Start and sync bits run countdown, wake at one
// RQ18: Software sync wake at hold-off plus six cycles
// RQ19: Synchronised hold-off lies between one and 65535
// RQ20: Pin sync wake at hold-off plus three cycles
// RQ21: Each channel selects any pin, start-on-pin bit
// RQ22: Sampled pin high enables countdown, wake at one; code starts it only on the synchronised rising edge
// RQ23: Sync reloads hold-off; unarmed sync does nothing
module chan_start_test (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_ext,
    input wire logic [7:0] reg_addr,
    input wire logic [1:0] reg_chan,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [19:0] reg_wdata,
    output logic [19:0] reg_rdata,
    output logic reg_ready,
    input wire logic [3:0] sync_pin,
    input wire logic [3:0] filter_valid,
    input wire logic [3:0][15:0] filter_i,
    input wire logic [3:0][15:0] filter_q,
    output logic [3:0] channel_sleep,
    output logic [3:0][1:0] test_source_sel,
    output logic [3:0][15:0] test_sample,
    output logic [3:0][7:0] coefficient_memory_addr,
    output logic [3:0] coefficient_memory_we,
    output logic [3:0][15:0] coefficient_memory_wdata,
    input wire logic [3:0][15:0] coefficient_memory_rdata,
    output logic [3:0][7:0] sample_memory_addr,
    output logic [3:0] sample_memory_we,
    output logic [3:0][15:0] sample_memory_wdata,
    input wire logic [3:0][15:0] sample_memory_rdata
);
    typedef struct packed {
        logic [3:0] sleep;
        logic [3:0][3:0] pin_en;
        logic [3:0] pin_start;
        logic [7:0] sync_ctl;
        logic [3:0][15:0] holdoff;
        logic [3:0][15:0] count;
        logic [3:0] run;
        logic [chan_sync_pkg::SOFT_PIPE-1:0][3:0] soft_pipe;
        logic [3:0] pin_dly;
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [3:0] pin_s3;
        logic [3:0][19:0] remaining;
        logic [3:0][1:0] src_bits;
        logic [3:0][1:0] sel;
        logic [3:0][15:0] prn;
        logic [3:0][2:0] phase;
        logic [3:0][15:0] sample;
        logic [19:0] rdata;
        logic ready;
    } ctl_state_t;

    ctl_state_t s;
    ctl_state_t n;

    logic [3:0] cm_busy;
    logic [3:0] cm_fail;
    logic [3:0] dm_busy;
    logic [3:0] dm_fail;
    logic [3:0] mem_start;
    logic [3:0] sig_load_a;
    logic [3:0] sig_load_b;
    logic [3:0] sig_shift;
    logic [3:0][15:0] sig_a;
    logic [3:0][15:0] sig_b;
    logic ext_wr;
    logic [3:0] soft_mask;
    logic [3:0] pin_rise;

    // ========================================================
    // Decoding helpers
    function automatic logic [1:0] src_decode(input logic [1:0] bits);
        chan_sync_pkg::test_src_t t;
        if (bits[1]) begin
            t = chan_sync_pkg::SRC_PRN;
        end else if (bits[0]) begin
            t = chan_sync_pkg::SRC_SINE;
        end else begin
            t = chan_sync_pkg::SRC_EXTERNAL;
        end
        src_decode = t;
    endfunction

    function automatic logic chan_wr(input logic [7:0] off, input logic [1:0] ch,
            input logic ext, input logic wr, input logic [7:0] a, input logic [1:0] c);
        chan_wr = wr && !ext && a == off && c == ch;
    endfunction

    // Eight-point full-scale sine; coarse, but it only excites the path
    function automatic logic [15:0] sine_point(input logic [2:0] ph);
        unique case (ph)
            3'h0, 3'h4: sine_point = 16'h0000;
            3'h1, 3'h3: sine_point = 16'h5A82;
            3'h2: sine_point = 16'h7FFF;
            3'h5, 3'h7: sine_point = 16'hA57E;
            3'h6: sine_point = 16'h8001;
        endcase
    endfunction

    // ========================================================
    // Event decoding
    assign ext_wr = reg_wr && reg_ext;
    always_comb begin
        soft_mask = '0;
        if (ext_wr && reg_addr == chan_sync_pkg::EXT_SYNC &&
                (reg_wdata[chan_sync_pkg::SYNC_SOFT_BIT] ||
                 reg_wdata[chan_sync_pkg::SYNC_START_BIT])) begin
            soft_mask = reg_wdata[3:0]; // RQ10
        end
    end
    // Edge taken after the second synchroniser stage only
    assign pin_rise = s.pin_s2 & ~s.pin_s3; // RQ22

    // ========================================================
    // Control and test sources
    always_comb begin
        n = s;
        n.ready = reg_wr || reg_rd;
        n.pin_s1 = sync_pin;
        n.pin_s2 = s.pin_s1;
        n.pin_s3 = s.pin_s2;
        // Six stages from write to counter load give hold-off plus six
        n.soft_pipe = {s.soft_pipe[chan_sync_pkg::SOFT_PIPE-2:0], soft_mask}; // RQ18
        if (ext_wr && reg_addr == chan_sync_pkg::EXT_SLEEP) begin
            n.sleep = reg_wdata[3:0]; // RQ14 RQ15
        end
        if (ext_wr && reg_addr == chan_sync_pkg::EXT_SYNC) begin
            n.sync_ctl = reg_wdata[7:0];
        end
        for (int c = 0; c < chan_sync_pkg::CHANNELS; c++) begin
            // Two synchroniser stages, edge and this stage make three
            n.pin_dly[c] = s.pin_start[c] && |(s.pin_en[c] & pin_rise); // RQ20 RQ21
            if (ext_wr && reg_addr == chan_sync_pkg::EXT_PIN_SYNC && reg_chan == c) begin
                n.pin_en[c] = reg_wdata[3:0]; // RQ21
                n.pin_start[c] = reg_wdata[chan_sync_pkg::PIN_START_BIT];
            end
            if (chan_wr(chan_sync_pkg::REG_START_HOLDOFF, 2'(c), reg_ext, reg_wr,
                    reg_addr, reg_chan)) begin
                n.holdoff[c] = reg_wdata[15:0]; // RQ19
            end
            if (chan_wr(chan_sync_pkg::REG_PATH_TEST, 2'(c), reg_ext, reg_wr,
                    reg_addr, reg_chan)) begin
                n.remaining[c] = reg_wdata; // RQ8
            end else if (sig_shift[c]) begin
                n.remaining[c] = s.remaining[c] - 20'h00001; // RQ8
            end
            if (chan_wr(chan_sync_pkg::REG_TEST_SOURCE, 2'(c), reg_ext, reg_wr,
                    reg_addr, reg_chan)) begin
                n.src_bits[c] = reg_wdata[chan_sync_pkg::SRC_PRN_BIT:chan_sync_pkg::SRC_SINE_BIT];
                n.sel[c] = src_decode(n.src_bits[c]); // RQ9
            end
            // Hold-off countdown; a sync without an armed channel never loads
            if (s.soft_pipe[chan_sync_pkg::SOFT_PIPE-1][c] || s.pin_dly[c]) begin
                n.count[c] = s.holdoff[c]; // RQ13 RQ23
                n.run[c] = 1'b1;
            end else if (s.run[c]) begin
                if (s.count[c] <= 16'h0001) begin
                    n.sleep[c] = 1'b0; // RQ17 RQ22
                    n.run[c] = 1'b0;
                end else begin
                    n.count[c] = s.count[c] - 16'h0001; // RQ17
                end
            end
            // Generators run only while the channel processes
            if (!s.sleep[c]) begin
                n.prn[c] = {s.prn[c][14:0], ^(s.prn[c] & chan_sync_pkg::PRN_TAPS)};
                n.phase[c] = s.phase[c] + 3'h1;
            end
            unique case (s.sel[c])
                chan_sync_pkg::SRC_PRN: n.sample[c] = s.prn[c]; // RQ9
                chan_sync_pkg::SRC_SINE: n.sample[c] = sine_point(s.phase[c]); // RQ9
                default: n.sample[c] = '0;
            endcase
        end
        if (reg_rd) begin
            n.rdata = '0;
            if (reg_ext) begin
                unique case (reg_addr)
                    chan_sync_pkg::EXT_SLEEP: n.rdata = {16'h0000, s.sleep};
                    chan_sync_pkg::EXT_PIN_SYNC:
                        n.rdata = {14'h0000, s.pin_start[reg_chan], 1'b0, s.pin_en[reg_chan]};
                    chan_sync_pkg::EXT_SYNC: n.rdata = {12'h000, s.sync_ctl};
                    default: n.rdata = '0;
                endcase
            end else begin
                unique case (reg_addr)
                    chan_sync_pkg::REG_START_HOLDOFF: n.rdata = {4'h0, s.holdoff[reg_chan]};
                    chan_sync_pkg::REG_SIG_A: n.rdata = {4'h0, sig_a[reg_chan]};
                    chan_sync_pkg::REG_SIG_B: n.rdata = {4'h0, sig_b[reg_chan]};
                    chan_sync_pkg::REG_PATH_TEST: n.rdata = s.remaining[reg_chan];
                    chan_sync_pkg::REG_MEM_TEST: begin
                        n.rdata[chan_sync_pkg::MEM_BUSY_BIT] =
                            cm_busy[reg_chan] | dm_busy[reg_chan]; // RQ3
                        n.rdata[chan_sync_pkg::MEM_CFAIL_BIT] = cm_fail[reg_chan]; // RQ4
                        n.rdata[chan_sync_pkg::MEM_DFAIL_BIT] = dm_fail[reg_chan]; // RQ4
                    end
                    chan_sync_pkg::REG_TEST_SOURCE: n.rdata = {12'h000, s.src_bits[reg_chan], 6'h00};
                    default: n.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.sleep <= chan_sync_pkg::SLEEP_RESET; // RQ14
            s.prn <= {4{chan_sync_pkg::PRN_SEED}};
        end else begin
            s <= n;
        end
    end

    // ========================================================
    // Per-channel test engines
    genvar g;
    generate
        for (g = 0; g < chan_sync_pkg::CHANNELS; g++) begin : chan
            // Host is trusted to have slept the channel first
            assign mem_start[g] = chan_wr(chan_sync_pkg::REG_MEM_TEST, 2'(g), reg_ext, reg_wr,
                reg_addr, reg_chan) && reg_wdata[chan_sync_pkg::MEM_ENABLE_BIT]; // RQ1 RQ5
            assign sig_load_a[g] = chan_wr(chan_sync_pkg::REG_SIG_A, 2'(g), reg_ext, reg_wr,
                reg_addr, reg_chan);
            assign sig_load_b[g] = chan_wr(chan_sync_pkg::REG_SIG_B, 2'(g), reg_ext, reg_wr,
                reg_addr, reg_chan);
            // Count of zero freezes both signatures
            assign sig_shift[g] = filter_valid[g] && !s.sleep[g] &&
                s.remaining[g] != 20'h00000; // RQ8 RQ12

            mem_march cm_test (
                .clock(clock), .reset_n(reset_n), .start(mem_start[g]),
                .busy(cm_busy[g]), .fail(cm_fail[g]), .mem_addr(coefficient_memory_addr[g]),
                .mem_we(coefficient_memory_we[g]), .mem_wdata(coefficient_memory_wdata[g]), .mem_rdata(coefficient_memory_rdata[g])
            );
            mem_march dm_test (
                .clock(clock), .reset_n(reset_n), .start(mem_start[g]),
                .busy(dm_busy[g]), .fail(dm_fail[g]), .mem_addr(sample_memory_addr[g]),
                .mem_we(sample_memory_we[g]), .mem_wdata(sample_memory_wdata[g]), .mem_rdata(sample_memory_rdata[g])
            );
            sig_compressor sig_i (
                .clock(clock), .reset_n(reset_n), .load(sig_load_a[g]),
                .load_value(reg_wdata[15:0]), .shift(sig_shift[g]),
                .data(filter_i[g]), .signature(sig_a[g])
            ); // RQ6
            sig_compressor sig_q (
                .clock(clock), .reset_n(reset_n), .load(sig_load_b[g]),
                .load_value(reg_wdata[15:0]), .shift(sig_shift[g]),
                .data(filter_q[g]), .signature(sig_b[g])
            ); // RQ6
        end
    endgenerate

    assign reg_rdata = s.rdata;
    assign reg_ready = s.ready;
    assign channel_sleep = s.sleep;
    assign test_source_sel = s.sel;
    assign test_sample = s.sample;

    // ========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence soft_issue_ch0;
        soft_mask[0] && s.sleep[0] && s.holdoff[0] == 16'h0002 && !s.run[0] &&
            !s.pin_start[0] && s.soft_pipe == '0;
    endsequence
    // A host write or pin arming during the wait may legally move the wake
    sequence host_quiet_ch0;
        (!reg_wr && !s.pin_start[0]) [*8];
    endsequence
    sequence asleep_then_awake_ch0;
        s.sleep[0] ##1 !s.sleep[0];
    endsequence

    a_soft_wake_time: assert property (soft_issue_ch0 ##1 host_quiet_ch0 // RQ18
        |-> asleep_then_awake_ch0)
        else $error("software sync wake time wrong");
    a_reset_sleep: assert property ($rose(reset_n) |-> s.sleep == 4'hF) // RQ14
        else $error("channels not asleep after reset");
    a_wake_now: assert property (ext_wr && reg_addr == chan_sync_pkg::EXT_SLEEP && // RQ15
        !reg_wdata[1] |=> !s.sleep[1])
        else $error("sleep clear did not wake channel");
    a_count_wake: assert property (s.run[0] && s.count[0] == 16'h0001 && // RQ17
        !s.soft_pipe[chan_sync_pkg::SOFT_PIPE-1][0] && !s.pin_dly[0] |=> !s.sleep[0])
        else $error("countdown reached one without waking");
    a_pin_load: assert property (s.pin_dly[1] |=> s.run[1] && // RQ23
        s.count[1] == $past(s.holdoff[1]))
        else $error("pin sync did not load hold-off");
    a_pin_arm: assert property (!s.pin_start[3] |=> !s.pin_dly[3]) // RQ21
        else $error("unarmed channel took a pin sync");
    a_pin_path: assert property (s.pin_start[1] && s.pin_en[1][1] && pin_rise[1] && // RQ22
        !(ext_wr && reg_addr == chan_sync_pkg::EXT_PIN_SYNC) |=> s.pin_dly[1] ##1 s.run[1])
        else $error("selected sync pin did not start countdown");
    a_count_exact: assert property (s.remaining[0] == 20'h00001 && sig_shift[0] && // RQ8 RQ12
        !sig_load_a[0] && !mem_start[0] && !(reg_wr && !reg_ext)
        |=> s.remaining[0] == 20'h00000 ##1 $stable(sig_a[0]))
        else $error("signature observed beyond programmed count");
    a_mem_status: assert property (mem_start[2] && !cm_busy[2] |=> cm_busy[2] [*3]) // RQ3 RQ5
        else $error("memory test status not busy");
endmodule
`default_nettype wire

// ---- pkg/chan_sync_pkg.sv ----
// Constants and types shared by the channel start and self-test logic.
// Assumes one 100 MHz master clock and an active-low asynchronous reset.
package chan_sync_pkg;
    // ========================================================
    // Sizes
    localparam int CHANNELS = 4;
    localparam int SYNC_PINS = 4;
    localparam int HOLD_W = 16;
    localparam int COUNT_W = 20;
    localparam int SIG_W = 16;
    localparam int MADDR_W = 8;
    localparam int MDATA_W = 16;
    localparam int RDATA_W = 20;
    // ========================================================
    // External (direct) register addresses
    localparam logic [7:0] EXT_SLEEP = 8'h03;
    localparam logic [7:0] EXT_PIN_SYNC = 8'h04;
    localparam logic [7:0] EXT_SYNC = 8'h05;
    // ========================================================
    // Channel register offsets
    localparam logic [7:0] REG_START_HOLDOFF = 8'h83;
    localparam logic [7:0] REG_SIG_A = 8'hA5;
    localparam logic [7:0] REG_SIG_B = 8'hA6;
    localparam logic [7:0] REG_PATH_TEST = 8'hA7;
    localparam logic [7:0] REG_MEM_TEST = 8'hA8;
    localparam logic [7:0] REG_TEST_SOURCE = 8'hA9;
    // ========================================================
    // Field positions
    localparam int SYNC_SOFT_BIT = 4;
    localparam int SYNC_START_BIT = 5;
    localparam int PIN_START_BIT = 5;
    localparam int MEM_BUSY_BIT = 0;
    localparam int MEM_CFAIL_BIT = 1;
    localparam int MEM_DFAIL_BIT = 2;
    localparam int MEM_ENABLE_BIT = 0;
    localparam int SRC_SINE_BIT = 6;
    localparam int SRC_PRN_BIT = 7;
    // ========================================================
    // Reset values and polynomials
    localparam logic [3:0] SLEEP_RESET = 4'hF;
    localparam logic [15:0] PRN_SEED = 16'hACE1;
    localparam logic [15:0] PRN_TAPS = 16'hB400;
    localparam logic [15:0] SIG_TAPS = 16'h8016;
    // ========================================================
    // Timing in master clock cycles, and the clock period in ns
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int SOFT_SYNC_LATENCY = 6;
    localparam int PIN_SYNC_LATENCY = 3;
    localparam int SOFT_PIPE = SOFT_SYNC_LATENCY;
    localparam int MEM_TEST_WAIT = 1600;
    // ========================================================
    // Types
    typedef enum logic [1:0] {SRC_EXTERNAL, SRC_PRN, SRC_SINE} test_src_t;
    typedef enum logic [2:0] {
        MARCH_IDLE, MARCH_WRITE, MARCH_READ, MARCH_WRITE_INV, MARCH_READ_INV
    } march_state_t;
endpackage

// ---- logic/sig_compressor.sv ----
// Multiple-input signature register for one filter output path.
// Assumes load and shift come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sig_compressor (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [15:0] load_value,
    input wire logic shift,
    input wire logic [15:0] data,
    output logic [15:0] signature
);
    typedef struct packed {
        logic [15:0] sig;
    } sig_state_t;

    sig_state_t s;
    sig_state_t n;

    // ========================================================
    // Compression
    always_comb begin
        n = s;
        if (load) begin
            n.sig = load_value;
        end else if (shift) begin
            // Feedback folds the old state so a single bad sample never cancels
            n.sig = {s.sig[14:0], ^(s.sig & chan_sync_pkg::SIG_TAPS)} ^ data; // RQ6
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign signature = s.sig;

    // ========================================================
    // Checks
    a_sig_frozen: assert property (@(posedge clock) disable iff (!reset_n) // RQ12
        !load && !shift |=> $stable(s.sig))
        else $error("signature moved without load or shift");
endmodule
`default_nettype wire

// ---- logic/mem_march.sv ----
// Write/read-back march test of one synchronous memory.
// Assumes the memory returns read data one clock after the address.
`timescale 1ns/1ps
`default_nettype none
module mem_march (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic start,
    output logic busy,
    output logic fail,
    output logic [7:0] mem_addr,
    output logic mem_we,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata
);
    typedef struct packed {
        chan_sync_pkg::march_state_t st;
        logic [7:0] addr;
        logic chk1;
        logic chk2;
        logic [15:0] exp1;
        logic [15:0] exp2;
        logic fail;
        logic [7:0] maddr;
        logic we;
        logic [15:0] wdata;
    } march_t;

    march_t s;
    march_t n;

    function automatic logic [15:0] pattern(input logic [7:0] a, input logic inv);
        pattern = inv ? ~{a, ~a} : {a, ~a};
    endfunction

    // ========================================================
    // Sequencer
    always_comb begin
        n = s;
        n.we = 1'b0;
        n.chk1 = 1'b0;
        n.chk2 = s.chk1;
        n.exp2 = s.exp1;
        if (s.chk2 && mem_rdata != s.exp2) begin
            n.fail = 1'b1; // RQ4
        end
        unique case (s.st)
            chan_sync_pkg::MARCH_IDLE: begin
                // Pending compares land before a restart clears the flag
                if (start && !s.chk1 && !s.chk2) begin
                    n.st = chan_sync_pkg::MARCH_WRITE;
                    n.addr = '0;
                    n.fail = 1'b0;
                end
            end
            chan_sync_pkg::MARCH_WRITE, chan_sync_pkg::MARCH_WRITE_INV: begin
                n.we = 1'b1;
                n.maddr = s.addr;
                n.wdata = pattern(s.addr, s.st == chan_sync_pkg::MARCH_WRITE_INV);
                n.addr = s.addr + 8'h01;
                if (s.addr == 8'hFF) begin
                    n.st = (s.st == chan_sync_pkg::MARCH_WRITE) ? chan_sync_pkg::MARCH_READ
                        : chan_sync_pkg::MARCH_READ_INV;
                end
            end
            chan_sync_pkg::MARCH_READ, chan_sync_pkg::MARCH_READ_INV: begin
                n.maddr = s.addr;
                n.chk1 = 1'b1;
                n.exp1 = pattern(s.addr, s.st == chan_sync_pkg::MARCH_READ_INV);
                n.addr = s.addr + 8'h01;
                if (s.addr == 8'hFF) begin
                    n.st = (s.st == chan_sync_pkg::MARCH_READ) ? chan_sync_pkg::MARCH_WRITE_INV
                        : chan_sync_pkg::MARCH_IDLE;
                end
            end
            default: n.st = chan_sync_pkg::MARCH_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    // Busy covers the read pipeline so the last compare lands first
    assign busy = (s.st != chan_sync_pkg::MARCH_IDLE) || s.chk1 || s.chk2; // RQ3
    assign fail = s.fail;
    assign mem_addr = s.maddr;
    assign mem_we = s.we;
    assign mem_wdata = s.wdata;

    // ========================================================
    // Checks
    a_start_busy: assert property (@(posedge clock) disable iff (!reset_n) // RQ3
        start && !busy |=> busy [*8])
        else $error("memory test did not report busy after start");
    a_result_stable: assert property (@(posedge clock) disable iff (!reset_n) // RQ4
        !busy && !start |=> $stable(fail))
        else $error("memory result changed while idle");
endmodule
`default_nettype wire

// ---- sim/mem_model.sv ----
// Synchronous memory banks, one per channel, for the march test.
// Assumes the address is registered one cycle before read data is used.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input wire logic clock,
    input wire logic [3:0][7:0] addr,
    input wire logic [3:0] we,
    input wire logic [3:0][15:0] wdata,
    input wire logic [3:0] fault,
    output logic [3:0][15:0] rdata
);
    logic [15:0] mem [4][256];
    // ========================================================
    // Fault flips bit 0 of each read, a stuck cell seen by the march
    always_ff @(posedge clock) begin
        for (int c = 0; c < 4; c++) begin
            if (we[c]) begin
                mem[c][addr[c]] <= wdata[c];
            end
            rdata[c] <= mem[c][addr[c]] ^ {15'h0, fault[c]};
        end
    end
endmodule
`default_nettype wire

// ---- sim/channel_start_sync_and_self_test_bench.sv ----
// Host-side bench: register accesses, sync pins and filter strobes.
// Assumes mem_model answers both memory test ports.
`timescale 1ns/1ps
`default_nettype none
module channel_start_sync_and_self_test_bench;
    logic clock = 1'b0, reset_n = 1'b0, reg_ext = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [1:0] reg_chan = 2'h0;
    logic [19:0] reg_wdata = 20'h0, reg_rdata, v;
    logic reg_ready;
    logic [3:0] sync_pin = 4'h0, filter_valid = 4'h0, channel_sleep, coefficient_memory_we, sample_memory_we;
    logic [3:0][15:0] filter_i = '0, filter_q = '0, test_sample, coefficient_memory_wdata, sample_memory_wdata;
    logic [3:0][15:0] coefficient_memory_rdata, sample_memory_rdata;
    logic [3:0][7:0] coefficient_memory_addr, sample_memory_addr;
    logic [3:0][1:0] test_source_sel;
    logic [15:0] sig_i = 16'h0, sig_q = 16'h0;
    int n_fail = 0, checked = 0, k;
    chan_start_test dut (.clock, .reset_n, .reg_ext, .reg_addr, .reg_chan, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata, .reg_ready, .sync_pin, .filter_valid, .filter_i, .filter_q,
        .channel_sleep, .test_source_sel, .test_sample, .coefficient_memory_addr, .coefficient_memory_we, .coefficient_memory_wdata,
        .coefficient_memory_rdata, .sample_memory_addr, .sample_memory_we, .sample_memory_wdata, .sample_memory_rdata);
    mem_model coefficient_memory (.clock, .addr(coefficient_memory_addr), .we(coefficient_memory_we), .wdata(coefficient_memory_wdata),
        .fault(4'hA), .rdata(coefficient_memory_rdata));
    mem_model sample_memory (.clock, .addr(sample_memory_addr), .we(sample_memory_we), .wdata(sample_memory_wdata),
        .fault(4'hC), .rdata(sample_memory_rdata));
    always #5 clock = ~clock;
    // ========================================================
    // Tasks
    task automatic acc(input logic w, e, input logic [7:0] a, input logic [1:0] c,
        input logic [19:0] d, output logic [19:0] q);
        @(posedge clock);
        {reg_ext, reg_addr, reg_chan, reg_wdata} <= {e, a, c, d};
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clock);
        {reg_wr, reg_rd} <= 2'b00;
        #1 q = reg_rdata;
        chk(20'(reg_ready), 20'h1);
    endtask
    task automatic chk(input logic [19:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wake(input int c, output int n);
        n = 0;
        while (channel_sleep[c] !== 1'b0 && n < 200) begin
            @(posedge clock);
            #1 n++;
        end
    endtask
    task automatic stop_test;
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ========================================================
    // Tests
    initial begin
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        #1 chk(20'(channel_sleep), 20'hF);
        acc(1, 0, 8'h83, 0, 20'h2, v);
        acc(1, 1, 8'h05, 0, 20'h11, v);
        wake(0, k);
        chk(20'(k), 20'd8);
        acc(1, 0, 8'h83, 1, 20'h4, v);
        acc(1, 1, 8'h04, 1, 20'h22, v);
        @(posedge clock);
        sync_pin <= 4'hE;
        wake(1, k);
        chk(20'(k), 20'd8);
        chk(20'(channel_sleep[3:2]), 20'h3);
        acc(1, 1, 8'h03, 0, 20'hF, v);
        #1 chk(20'(channel_sleep), 20'hF);
        for (int c = 0; c < 4; c++) acc(1, 0, 8'hA8, 2'(c), 20'h1, v);
        acc(0, 0, 8'hA8, 0, 20'h0, v);
        chk(v, 20'h1);
        repeat (1600) @(posedge clock);
        for (int c = 0; c < 4; c++) begin
            acc(0, 0, 8'hA8, 2'(c), 20'h0, v);
            chk(v, {17'h0, c[1], c[0], 1'b0});
        end
        acc(0, 0, 8'h10, 0, 20'h0, v);
        chk(v, 20'h0);
        acc(1, 0, 8'hA5, 0, 20'h0, v);
        acc(1, 0, 8'hA6, 0, 20'h0, v);
        acc(1, 0, 8'hA7, 0, 20'h3, v);
        acc(1, 0, 8'h83, 0, 20'h1, v);
        acc(1, 1, 8'h03, 0, 20'h0, v);
        @(posedge clock);
        #1 chk(20'(channel_sleep), 20'h0);
        // Five strobes, only three may count; the rest must leave it frozen
        for (int i = 0; i < 5; i++) begin
            @(posedge clock);
            filter_valid <= 4'h1;
            filter_i[0] <= 16'(16'h1357 * (i + 1));
            filter_q[0] <= 16'(16'hB00F - i);
            if (i < 3) begin
                sig_i = {sig_i[14:0], ^(sig_i & 16'h8016)} ^ 16'(16'h1357 * (i + 1));
                sig_q = {sig_q[14:0], ^(sig_q & 16'h8016)} ^ 16'(16'hB00F - i);
            end
            @(posedge clock);
            filter_valid <= 4'h0;
        end
        acc(0, 0, 8'hA5, 0, 20'h0, v);
        chk(v, {4'h0, sig_i});
        acc(0, 0, 8'hA6, 0, 20'h0, v);
        chk(v, {4'h0, sig_q});
        acc(0, 0, 8'hA7, 0, 20'h0, v);
        chk(v, 20'h0);
        for (int s = 0; s < 4; s++) begin
            acc(1, 0, 8'hA9, 1, 20'(s * 64), v);
            repeat (2) @(posedge clock);
            #1 chk(20'(test_source_sel[1]), s[1] ? 20'h1 : (s[0] ? 20'h2 : 20'h0));
        end
        k = int'(test_sample[1]);
        @(posedge clock);
        #1 chk(20'(test_sample[1]), 20'({k[14:0], ^(k[15:0] & 16'hB400)}));
        stop_test();
    end
    // Bound on a hung handshake or a channel that never wakes
    initial begin
        repeat (6000) @(posedge clock);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
